// File: cwm_pkg.sv
// ==========================================================
// shared constants of the wake frame match configuration
package cwm_pkg;

  // ==========================================================
  // register addresses on the serial register port
  localparam logic [6:0] CWM_ADDR_DLC      = 7'h36;
  localparam logic [6:0] CWM_ADDR_BYTES_76 = 7'h37;
  localparam logic [6:0] CWM_ADDR_BYTES_54 = 7'h38;
  localparam logic [6:0] CWM_ADDR_BYTES_32 = 7'h39;
  localparam logic [6:0] CWM_ADDR_BYTES_10 = 7'h3A;
  localparam logic [6:0] CWM_ADDR_FD_CFG   = 7'h3B;

  // ==========================================================
  // field positions of the fd tolerance and length code registers
  localparam int CWM_FD_EN_BIT      = 0;
  localparam int CWM_FD_FILT_LSB    = 1;
  localparam int CWM_FD_FILT_MSB    = 3;
  localparam int CWM_FD_ERRDIS_BIT  = 5;
  localparam int CWM_DLC_MSB        = 3;

  // ==========================================================
  // values after power-on or soft reset
  localparam logic [15:0] CWM_RST_REG  = 16'h0000;
  localparam logic [3:0]  CWM_RST_DLC  = 4'h0;
  localparam logic [2:0]  CWM_RST_FILT = 3'h0;
  localparam logic [63:0] CWM_RST_DATA = 64'h0000_0000_0000_0000;

  // ==========================================================
  // length code limits
  localparam logic [3:0] CWM_MAX_BYTES = 4'h8;

  // ==========================================================
  // dominant filter times, ns, and cycle counts at 25 MHz
  localparam int CWM_CLK_PERIOD_NS = 40;
  localparam int CWM_FILT_STEP_NS  = 50;
  localparam int CWM_FILT_TOP_NS   = 775;
  localparam int CWM_FILT_CODE_TOP = 7;
  // least times round up to whole cycles
  localparam int CWM_FILT_TOP_CYC  =
    (CWM_FILT_TOP_NS + CWM_CLK_PERIOD_NS - 1) / CWM_CLK_PERIOD_NS;

  function automatic logic [4:0] cwm_filt_cycles(input logic [2:0] code);
    int ns;
    ns = (code == 3'(CWM_FILT_CODE_TOP)) ? CWM_FILT_TOP_NS
                                         : (int'(code) + 1) * CWM_FILT_STEP_NS;
    return 5'((ns + CWM_CLK_PERIOD_NS - 1) / CWM_CLK_PERIOD_NS);
  endfunction

endpackage

// File: cwm_payload_match.sv
`timescale 1ns/1ps
// ==========================================================
// payload and length code comparison against the configuration
module cwm_payload_match
  import cwm_pkg::*;
(
  input  wire logic [3:0]  cfg_dlc_in,
  input  wire logic [63:0] cfg_data_in,
  input  wire logic [3:0]  frame_dlc_in,
  input  wire logic [63:0] frame_data_in,
  output logic      [3:0]  byte_count_out,
  output logic             match_out
);

  logic [7:0] byte_ok;

  // codes 8..15 all mean eight bytes
  assign byte_count_out = (cfg_dlc_in >= CWM_MAX_BYTES) ? CWM_MAX_BYTES : cfg_dlc_in;

  // bytes beyond the count are ignored
  generate
    for (genvar k = 0; k < 8; k++) begin : g_byte
      assign byte_ok[k] = (4'(k) >= byte_count_out) ||
                          (cfg_data_in[8*k +: 8] == frame_data_in[8*k +: 8]);
    end
  endgenerate

  // code must agree bit by bit, not only by byte count
  assign match_out = (cfg_dlc_in == frame_dlc_in) && (&byte_ok);

endmodule

// File: cwm_wake_frame_config.sv
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// - power-on or soft reset clears length code, payload and fd registers
// - restart keeps length code field; upper bits always zero
// - restart leaves payload byte registers untouched
// - restart leaves fd bits 5 and 3:0; bits 15:6, 4 zero
// - length codes zero to seven mean that many data bytes
// - length codes eight to fifteen mean eight data bytes
// - wake frame accepted only when its length code matches all four bits
// - payload held as byte pairs, 0x37 bytes 7/6 down to 0x3A bytes 1/0
// - fd register bit 0 enables fd tolerant mode
// - bits 3:1 pick filter time, 50 ns steps to 350, top 775 ns
// - bit 5 suppresses wake error counter, only with fd tolerant mode on
// - silence timeout clears the error counter disable bit
// - fd register reserved bits always read zero
module cwm_wake_frame_config
  import cwm_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        soft_reset_in,
  input  wire logic        restart_in,
  input  wire logic [6:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        silence_expired_in,
  input  wire logic        frame_check_in,
  input  wire logic [3:0]  frame_dlc_in,
  input  wire logic [63:0] frame_data_in,
  output logic             wake_match_out,
  output logic             match_valid_out,
  output logic      [3:0]  cfg_dlc_out,
  output logic      [3:0]  payload_byte_count_out,
  output logic      [63:0] payload_bytes_out,
  output logic             fd_tolerant_enable_out,
  output logic      [2:0]  fd_dominant_filter_time_out,
  output logic      [4:0]  fd_dominant_filter_time_cycles_out,
  output logic             wake_error_counter_disable_out,
  output logic             wake_error_counter_active_out
);

  // ==========================================================
  // configuration storage
  logic [3:0]  dlc;
  logic [63:0] payload;
  logic        fd_en;
  logic [2:0]  fd_filt;
  logic        err_dis;
  logic        clear_all;
  logic        wr_dlc;
  logic        wr_fd;
  logic [3:0]  next_count;
  logic        next_match;

  // soft reset acts like power-on; restart deliberately touches nothing
  assign clear_all = !rst_n_in || soft_reset_in;
  assign wr_dlc    = reg_wr_in && (reg_addr_in == CWM_ADDR_DLC);
  assign wr_fd     = reg_wr_in && (reg_addr_in == CWM_ADDR_FD_CFG);

  // length code, upper bits are not stored at all
  always_ff @(posedge clock_in) begin
    if (clear_all) begin
      dlc <= CWM_RST_DLC;
    end else if (wr_dlc) begin
      dlc <= reg_wdata_in[CWM_DLC_MSB:0];
    end
  end

  // payload pairs: lower address holds the higher bytes
  generate
    for (genvar p = 0; p < 4; p++) begin : g_pair
      localparam logic [6:0] PAIR_ADDR = CWM_ADDR_BYTES_10 - 7'(p);
      always_ff @(posedge clock_in) begin
        if (clear_all) begin
          payload[16*p +: 16] <= CWM_RST_DATA[16*p +: 16];
        end else if (reg_wr_in && (reg_addr_in == PAIR_ADDR)) begin
          payload[16*p +: 16] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // fd enable and filter code, written together
  always_ff @(posedge clock_in) begin
    if (clear_all) begin
      fd_en   <= 1'b0;
      fd_filt <= CWM_RST_FILT;
    end else if (wr_fd) begin
      fd_en   <= reg_wdata_in[CWM_FD_EN_BIT];
      fd_filt <= reg_wdata_in[CWM_FD_FILT_MSB:CWM_FD_FILT_LSB];
    end
  end

  // hardware clear at silence timeout wins over a same-cycle write,
  // so a stale disable never survives into the next wake attempt
  always_ff @(posedge clock_in) begin
    if (clear_all) begin
      err_dis <= 1'b0;
    end else if (silence_expired_in) begin
      err_dis <= 1'b0;
    end else if (wr_fd) begin
      err_dis <= reg_wdata_in[CWM_FD_ERRDIS_BIT];
    end
  end

  // ==========================================================
  // register read port, one cycle latency, unmapped reads zero
  always_ff @(posedge clock_in) begin
    if (clear_all) begin
      reg_rdata_out <= CWM_RST_REG;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        CWM_ADDR_DLC:      reg_rdata_out <= {12'h000, dlc};
        CWM_ADDR_BYTES_76: reg_rdata_out <= payload[63:48];
        CWM_ADDR_BYTES_54: reg_rdata_out <= payload[47:32];
        CWM_ADDR_BYTES_32: reg_rdata_out <= payload[31:16];
        CWM_ADDR_BYTES_10: reg_rdata_out <= payload[15:0];
        CWM_ADDR_FD_CFG:   reg_rdata_out <= {10'h000, err_dis, 1'b0, fd_filt, fd_en};
        default:           reg_rdata_out <= CWM_RST_REG;
      endcase
    end
  end

  // ==========================================================
  // frame comparison
  cwm_payload_match u_match (
    .cfg_dlc_in     (dlc),
    .cfg_data_in    (payload),
    .frame_dlc_in   (frame_dlc_in),
    .frame_data_in  (frame_data_in),
    .byte_count_out (next_count),
    .match_out      (next_match)
  );

  // verdict registered one cycle after the check strobe
  always_ff @(posedge clock_in) begin
    if (clear_all) begin
      wake_match_out  <= 1'b0;
      match_valid_out <= 1'b0;
    end else begin
      match_valid_out <= frame_check_in;
      wake_match_out  <= frame_check_in && next_match;
    end
  end

  // ==========================================================
  // settings toward the decoder, all from flip-flops
  assign cfg_dlc_out                    = dlc;
  assign payload_bytes_out              = payload;
  assign fd_tolerant_enable_out         = fd_en;
  assign fd_dominant_filter_time_out    = fd_filt;
  assign wake_error_counter_disable_out = err_dis;

  // derived settings, one cycle behind the register
  always_ff @(posedge clock_in) begin
    if (clear_all) begin
      payload_byte_count_out        <= CWM_RST_DLC;
      fd_dominant_filter_time_cycles_out          <= cwm_filt_cycles(CWM_RST_FILT);
      wake_error_counter_active_out <= 1'b1;
    end else begin
      payload_byte_count_out        <= next_count;
      fd_dominant_filter_time_cycles_out          <= cwm_filt_cycles(fd_filt);
      // disable only counts while fd tolerant mode is on
      wake_error_counter_active_out <= !(err_dis && fd_en);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  soft_reset_clear_a: assert property (soft_reset_in |=>
    (dlc == 4'h0) && (payload == 64'h0) && !fd_en && (fd_filt == 3'h0) && !err_dis)
    else $error("soft reset left configuration set");

  restart_keep_a: assert property (restart_in && !soft_reset_in && !reg_wr_in
    |=> $stable(payload) && $stable(dlc) && $stable(fd_filt))
    else $error("restart changed configuration");

  dlc_write_a: assert property (wr_dlc && !soft_reset_in
    |=> dlc == $past(reg_wdata_in[3:0]))
    else $error("length code write not stored");

  pair_write_a: assert property (reg_wr_in && !soft_reset_in
    && reg_addr_in == CWM_ADDR_BYTES_76 |=> payload[63:48] == $past(reg_wdata_in))
    else $error("top byte pair write misplaced");

  fd_write_a: assert property (wr_fd && !soft_reset_in && !silence_expired_in
    |=> fd_en == $past(reg_wdata_in[0]) && fd_filt == $past(reg_wdata_in[3:1])
        && err_dis == $past(reg_wdata_in[5]))
    else $error("fd register fields not updated together");

  silence_clear_a: assert property (silence_expired_in |=> !err_dis)
    else $error("silence timeout did not clear disable bit");

  reserved_zero_a: assert property (reg_rd_in && reg_addr_in == CWM_ADDR_FD_CFG
    |=> reg_rdata_out[15:6] == 10'h000 && !reg_rdata_out[4])
    else $error("fd reserved bits read nonzero");

  // soft reset forces the derived outputs, so those edges are left out
  err_active_a: assert property (!soft_reset_in |=> wake_error_counter_active_out ==
    !($past(err_dis) && $past(fd_en)))
    else $error("error counter activity wrong");

  count_eight_a: assert property (dlc[3] && !soft_reset_in
    |=> payload_byte_count_out == 4'h8)
    else $error("high length code not eight bytes");

  count_low_a: assert property (!dlc[3] && !soft_reset_in
    |=> payload_byte_count_out == $past(dlc))
    else $error("low length code count wrong");

  dlc_exact_a: assert property (frame_check_in && frame_dlc_in != dlc
    |=> !wake_match_out)
    else $error("match with differing length code");

  filter_top_a: assert property (fd_filt == 3'h7 && !soft_reset_in
    |=> fd_dominant_filter_time_cycles_out == 5'(CWM_FILT_TOP_CYC))
    else $error("top filter time wrong");

  match_seen_c:   cover property (frame_check_in ##1 wake_match_out);
  fd_on_c:        cover property (wr_fd ##1 fd_en && err_dis);
  silence_c:      cover property (err_dis ##1 silence_expired_in ##1 !err_dis);
  short_frame_c:  cover property (frame_check_in && dlc == 4'h3 ##1 wake_match_out);

endmodule

// File: cwm_frame_source.sv
`timescale 1ns/1ps
// ==========================================================
// far side: a bus node handing decoded wake frames to the block
module cwm_frame_source (
  input  wire logic        clock_in,
  output logic             frame_check_out,
  output logic      [3:0]  frame_dlc_out,
  output logic      [63:0] frame_data_out
);
  initial begin
    frame_check_out = 1'b0;
    frame_dlc_out   = 4'h0;
    frame_data_out  = 64'h0;
  end
  // one frame, then idle lines invert so stale data never matches
  task automatic send(input logic [3:0] dlc, input logic [63:0] data);
    @(negedge clock_in);
    frame_check_out = 1'b1;
    frame_dlc_out   = dlc;
    frame_data_out  = data;
    @(negedge clock_in);
    frame_check_out = 1'b0;
    frame_dlc_out   = ~dlc;
    frame_data_out  = ~data;
  endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench: register model in an array of words, compared at every result
module tb_top;
  logic        clock_in           = 1'b0;
  logic        rst_n_in           = 1'b0;
  logic        soft_reset_in      = 1'b0;
  logic        restart_in         = 1'b0;
  logic [6:0]  reg_addr_in        = 7'h00;
  logic [15:0] reg_wdata_in       = 16'h0000;
  logic        reg_wr_in          = 1'b0;
  logic        reg_rd_in          = 1'b0;
  logic        silence_expired_in = 1'b0;
  logic        frame_check_in;
  logic [3:0]  frame_dlc_in;
  logic [63:0] frame_data_in;
  logic [15:0] reg_rdata_out;
  logic        wake_match_out, match_valid_out, fd_tolerant_enable_out;
  logic [3:0]  cfg_dlc_out, payload_byte_count_out;
  logic [63:0] payload_bytes_out;
  logic [2:0]  fd_dominant_filter_time_out;
  logic [4:0]  fd_dominant_filter_time_cycles_out;
  logic        wake_error_counter_disable_out, wake_error_counter_active_out;
  logic [15:0] mdl [54:59] = '{default: 16'h0000};
  int          fails = 0;
  int          tests_run = 0;
  int          seed = 32'hC402CA3C;
  int          n;
  logic [63:0] cd;

  always #20 clock_in = ~clock_in;

  cwm_wake_frame_config i_cwm_wake_frame_config (.clock_in, .rst_n_in, .soft_reset_in,
    .restart_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .silence_expired_in, .frame_check_in, .frame_dlc_in, .frame_data_in, .wake_match_out,
    .match_valid_out, .cfg_dlc_out, .payload_byte_count_out, .payload_bytes_out,
    .fd_tolerant_enable_out, .fd_dominant_filter_time_out, .fd_dominant_filter_time_cycles_out,
    .wake_error_counter_disable_out, .wake_error_counter_active_out);
  cwm_frame_source i_cwm_frame_source (.clock_in(clock_in), .frame_check_out(frame_check_in),
    .frame_dlc_out(frame_dlc_in), .frame_data_out(frame_data_in));

  // ==========================================================
  // helpers
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // writable fields only; reserved bits are dropped
  function automatic logic [15:0] wmask(int a);
    return (a == 54) ? 16'h000F : (a == 59) ? 16'h002F : 16'hFFFF;
  endfunction
  function automatic logic [63:0] cfgd();
    return {mdl[55], mdl[56], mdl[57], mdl[58]};
  endfunction
  function automatic int fcyc(int c);
    int ns;
    ns = (c == 7) ? 775 : (c + 1) * 50;
    return (ns + 39) / 40;
  endfunction
  function automatic logic expm(logic [3:0] fd, logic [63:0] dt);
    logic [63:0] c;
    int k;
    c = cfgd();
    if (fd !== mdl[54][3:0])
      return 1'b0;
    for (k = 0; k < ((mdl[54][3:0] > 8) ? 8 : mdl[54][3:0]); k++)
      if (dt[8*k+:8] !== c[8*k+:8]) return 1'b0;
    return 1'b1;
  endfunction
  task automatic wr(input int a, input logic [15:0] d);
    @(negedge clock_in);
    reg_wr_in = 1'b1;
    reg_addr_in = 7'(a);
    reg_wdata_in = d;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
    reg_wdata_in = ~d;
    if (a >= 54 && a <= 59) mdl[a] = d & wmask(a);
  endtask
  task automatic rd(input int a);
    @(negedge clock_in);
    reg_rd_in = 1'b1;
    reg_addr_in = 7'(a);
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    chk(reg_rdata_out, (a >= 54 && a <= 59) ? mdl[a] : 16'h0000);
  endtask
  // 0 restart, 1 silence timeout, 2 soft reset; one cycle each
  task automatic pulse(input int which);
    @(negedge clock_in);
    if (which == 0) restart_in = 1'b1;
    else if (which == 1) silence_expired_in = 1'b1;
    else soft_reset_in = 1'b1;
    @(negedge clock_in);
    restart_in = 1'b0;
    silence_expired_in = 1'b0;
    soft_reset_in = 1'b0;
  endtask
  // derived outputs trail the register by one cycle
  task automatic cfg_chk();
    @(negedge clock_in);
    chk(payload_bytes_out, cfgd());
    chk(cfg_dlc_out, mdl[54][3:0]);
    chk(payload_byte_count_out, (mdl[54][3:0] > 8) ? 8 : mdl[54][3:0]);
    chk(fd_tolerant_enable_out, mdl[59][0]);
    chk(fd_dominant_filter_time_out, mdl[59][3:1]);
    chk(fd_dominant_filter_time_cycles_out, fcyc(mdl[59][3:1]));
    chk(wake_error_counter_disable_out, mdl[59][5]);
    chk(wake_error_counter_active_out, !(mdl[59][5] && mdl[59][0]));
    chk(match_valid_out, 1'b0);
    chk(wake_match_out, 1'b0);
  endtask
  task automatic frm(input logic [3:0] d, input logic [63:0] dt);
    i_cwm_frame_source.send(d, dt);
    chk(match_valid_out, 1'b1);
    chk(wake_match_out, expm(d, dt));
  endtask
  task automatic rd_all();
    for (int a = 53; a <= 60; a++) rd(a);
  endtask

  // ==========================================================
  // watchdog, far beyond the roughly five hundred cycles of the run
  initial begin
    repeat (20000) @(posedge clock_in);
    fails++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(negedge clock_in);
    rst_n_in = 1'b1;
    rd_all();
    cfg_chk();
    for (int i = 0; i < 6; i++) begin
      for (int a = 54; a <= 59; a++) wr(a, 16'($random(seed)));
      rd_all();
      cfg_chk();
    end
    // reserved ones written on purpose, every filter code and enable mix
    for (int c = 0; c < 8; c++) begin
      wr(59, {10'h3FF, 1'(c >> 1), 1'b1, 3'(c), 1'(c)});
      cfg_chk();
    end
    for (int d = 0; d < 16; d++) begin
      wr(54, 16'hFFF0 | 16'(d));
      cfg_chk();
      cd = cfgd();
      n = (d > 8) ? 8 : d;
      frm(4'(d), cd);
      frm(4'(d), cd ^ (64'hA5 << (8 * n)));
      if (n > 0) frm(4'(d), cd ^ (64'h01 << (8 * (n - 1))));
      frm(4'(d) ^ 4'h1, cd);
    end
    pulse(0);
    rd_all();
    // fd mode on; choosing the wake receiver is a setting outside this block
    wr(59, 16'h0021);
    cfg_chk();
    pulse(1);
    mdl[59][5] = 1'b0;
    cfg_chk();
    pulse(2);
    mdl = '{default: 16'h0000};
    rd_all();
    cfg_chk();
    // power-on reset in mid-run over a loaded configuration
    for (int a = 54; a <= 59; a++) wr(a, 16'($random(seed)));
    @(negedge clock_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    mdl = '{default: 16'h0000};
    rd_all();
    cfg_chk();
    give_verdict();
  end
endmodule
